// file: core/mem_cmd_consts.svh
// Offsets, field positions, codes and limits for the memory access command interpreter.
`ifndef MEM_CMD_CONSTS_SVH
`define MEM_CMD_CONSTS_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_RESULT 8'h10
`define OFS_PASSWORD 8'h14
`define OFS_MBOX_BASE 8'h80
`define CMD_CODE_MEM_ACCESS 5'h01
`define CMD_DIR_BIT 0
`define CMD_VERIFY_BIT 1
`define MAX_WRITE_BYTES 8'h18
`define MAX_READ_BYTES 8'h1E
`define MBOX_PAYLOAD_FIRST 5'h08
`define MBOX_COUNT 32
`define PASSWORD_RESET 32'h5A5A_A5A5
`define ERR_NONE 3'h0
`define ERR_RIGHTS 3'h5
`define ERR_RANGE 3'h6
`define ERR_COMMAND 3'h7
`define ERR_VERIFY 3'h4
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1
`define IRQ_WIDTH 2
`endif

// file: core/mem_cmd_pkg.sv
// Types shared by the memory access command interpreter.
package mem_cmd_pkg;
	typedef enum logic [2:0] {
		SPACE_FLASH_LO = 3'h0,
		SPACE_ROM = 3'h1,
		SPACE_RAM = 3'h2,
		SPACE_FAST_GPIO = 3'h3,
		SPACE_PERIPH8 = 3'h4,
		SPACE_PERIPH16 = 3'h5,
		SPACE_FLASH_HI = 3'h6,
		SPACE_RESERVED = 3'h7
	} space_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DECODE = 3'h1,
		ST_ISSUE = 3'h2,
		ST_WAIT = 3'h3,
		ST_VERIFY = 3'h4,
		ST_DONE = 3'h5
	} state_t;
endpackage

// file: core/space_decode.sv
// Memory-space decoder: legality, unlock need and upper address bits.
`timescale 1ns/100ps
`default_nettype none
module space_decode (
	// Space selector and access direction.
	input wire logic [2:0] space,
	input wire logic is_read,
	// Decode results.
	output logic reserved,
	output logic needs_unlock,
	output logic write_barred,
	output logic [7:0] upper_addr
);
	// Upper address byte comes from the space code alone.
	always_comb begin
		reserved = 1'b0;
		needs_unlock = 1'b0;
		write_barred = 1'b0;
		upper_addr = 8'h00;
		case (mem_cmd_pkg::space_t'(space))
			mem_cmd_pkg::SPACE_FLASH_LO: upper_addr = 8'h00;
			mem_cmd_pkg::SPACE_ROM: begin
				upper_addr = 8'h40;
				needs_unlock = 1'b1;
				write_barred = ~is_read;
			end
			mem_cmd_pkg::SPACE_RAM: upper_addr = 8'h80;
			mem_cmd_pkg::SPACE_FAST_GPIO: upper_addr = 8'hC0;
			mem_cmd_pkg::SPACE_PERIPH8: upper_addr = 8'hFF;
			mem_cmd_pkg::SPACE_PERIPH16: begin
				upper_addr = 8'hFE;
				needs_unlock = 1'b1;
			end
			mem_cmd_pkg::SPACE_FLASH_HI: upper_addr = 8'h01;
			default: reserved = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// file: core/byte_compare.sv
// Verify checker: compares a stored byte with the intended byte.
`timescale 1ns/100ps
`default_nettype none
module byte_compare (
	// Compare inputs.
	input wire logic enable,
	input wire logic [7:0] expected,
	input wire logic [7:0] observed,
	// Compare result.
	output logic mismatch
);
	// A mismatch is only reported while checking is enabled.
	assign mismatch = enable & (expected != observed);
endmodule
`default_nettype wire

// file: core/mem_access_cmd.sv
// Memory access command interpreter with APB mailboxes and a byte memory port.
// Notes on behaviour
// RULE1: Direction bit 0 writes, 1 reads; verify only matters on writes.
// RULE2: Verify set on a write reads back each byte and compares it.
// RULE3: Three-bit space code selects one of seven spaces; 111 is reserved.
// RULE4: ROM and 16-bit peripheral accesses need a matching interpreter password.
// RULE5: Writes take 1 to 24 bytes; larger counts error; zero is a no-op.
// RULE6: Reads take 1 to 30 bytes; other counts report an error.
// RULE7: Password is ignored completely for spaces without unlock.
// RULE8: Host always fills all four password mailboxes, bits 15:8 and 7:0 last.
// RULE9: Mailboxes 6 and 7 give the low sixteen bits of the first address.
// RULE10: Upper address bits come from the space code, never the packet.
// RULE11: Write payload comes from mailbox 8 onward, exactly count bytes.
// RULE12: Host sizes flash programming payloads in multiples of four bytes.
// RULE13: Command code 0x01 in bits 7:3; verify is bit 1, direction bit 0.
// RULE14: Address advances by one for each successive byte.
// RULE15: Complete flag is 0 while running and 1 once finished or aborted.
`include "mem_cmd_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module mem_access_cmd (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Byte memory port towards the system bus.
	output logic mem_req,
	output logic mem_we,
	output logic [23:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// Interrupt.
	output logic irq
);
	// Mailbox array and the software registers beside it.
	logic [7:0] mbox_q [0:`MBOX_COUNT-1];
	logic [31:0] password_q;
	logic [`IRQ_WIDTH-1:0] irq_status_q;
	logic [`IRQ_WIDTH-1:0] irq_mask_q;

	// Sequencer state and the packet fields it latches at decode.
	mem_cmd_pkg::state_t state_q;
	logic busy_q;
	logic complete_q;
	logic [2:0] err_q;
	logic [15:0] low_addr_q;
	logic [4:0] count_q;
	logic [4:0] idx_q;
	logic readback_q;

	// Verify outcome; only the first failing address is kept.
	logic verify_failed_q;
	logic [15:0] verify_addr_q;

	// One-cycle events that feed the sticky interrupt status.
	logic ev_done;
	logic ev_err;

	// APB decode.
	logic wr_en;
	logic rd_en;
	logic start;
	logic mbox_sel;
	logic [4:0] mbox_idx;

	// Packet fields read straight from the mailboxes.
	logic is_read;
	logic verify_on;
	logic [2:0] space;
	logic [7:0] number;
	logic [31:0] cmd_password;

	// Space decode results.
	logic reserved;
	logic needs_unlock;
	logic write_barred;
	logic [7:0] upper_addr;

	// Payload byte in flight and the verify compare on it.
	logic mismatch;
	logic [7:0] payload;

	// Byte count limit test, used for both directions.
	// The count is widened to a byte so that it compares directly with the byte-wide limit constant of either direction.
	// A zero count never passes; the write no-op is caught before this test is made.
	function automatic logic count_ok(input logic [7:0] n, input logic [7:0] limit);
		count_ok = (n != 8'h00) && (n <= limit);
	endfunction

	// APB decode; the slave answers with no wait state.
	// Every register answers in the access phase, so pready can be tied high.
	// A start while a command runs is dropped, so the packet cannot change under it.
	// Unmapped offsets answer with an error response and read as zero.
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign mbox_sel = paddr[7] & (paddr[1:0] == 2'h0);
	assign mbox_idx = paddr[6:2];
	assign start = wr_en & (paddr == `OFS_CTRL) & pwdata[0] & ~busy_q;
	assign pslverr = psel & penable & ~mbox_sel & (paddr != `OFS_CTRL) & (paddr != `OFS_STATUS)
		& (paddr != `OFS_IRQ_STATUS) & (paddr != `OFS_IRQ_MASK) & (paddr != `OFS_RESULT)
		& (paddr != `OFS_PASSWORD);

	// Packet fields taken from the mailbox array.
	// Mailbox writes are refused while busy, so APB cannot change these fields during a command.
	// Read data lands from mailbox 2 up, which leaves mailboxes 0 and 1 intact but overwrites the password fields.
	assign is_read = mbox_q[0][`CMD_DIR_BIT]; // [RULE1]
	assign verify_on = mbox_q[0][`CMD_VERIFY_BIT] & ~is_read; // [RULE1] [RULE13]
	assign space = mbox_q[1][7:5]; // [RULE3]
	assign number = {3'h0, mbox_q[1][4:0]};
	assign cmd_password = {mbox_q[2], mbox_q[3], mbox_q[4], mbox_q[5]}; // [RULE8]
	assign payload = mbox_q[5'(`MBOX_PAYLOAD_FIRST + idx_q)]; // [RULE11]

	space_decode u_space (
		.space(space),
		.is_read(is_read),
		.reserved(reserved),
		.needs_unlock(needs_unlock),
		.write_barred(write_barred),
		.upper_addr(upper_addr)
	);

	byte_compare u_cmp (
		.enable(readback_q),
		.expected(payload),
		.observed(mem_rdata),
		.mismatch(mismatch)
	);

	// Memory port; upper address from the space, low part advancing per byte.
	// The request is a level that stands from the wait state until the acknowledge.
	// Address and data are combinational, but their sources only move between requests.
	// The low part wraps within sixteen bits, as the packet gives no more.
	assign mem_req = (state_q == mem_cmd_pkg::ST_WAIT);
	assign mem_we = ~is_read & ~readback_q;
	assign mem_addr = {upper_addr, 16'(low_addr_q + {11'h000, idx_q})}; // [RULE10] [RULE14]
	assign mem_wdata = payload;

	// Command sequencer.
	// Decode checks run in a fixed order, so one packet reports only its first fault.
	// A verified write spends two requests per byte: the store and then its readback.
	// Read data is only valid with the acknowledge, so it is used in the wait state.
	// The complete flag falls at start and rises once the done state is reached.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= mem_cmd_pkg::ST_IDLE;
			busy_q <= 1'b0;
			complete_q <= 1'b0;
			err_q <= `ERR_NONE;
			low_addr_q <= 16'h0000;
			count_q <= 5'h00;
			idx_q <= 5'h00;
			readback_q <= 1'b0;
		end else begin
			case (state_q)
				mem_cmd_pkg::ST_IDLE: begin
					if (start) begin
						state_q <= mem_cmd_pkg::ST_DECODE;
						busy_q <= 1'b1;
						complete_q <= 1'b0; // [RULE15]
						err_q <= `ERR_NONE;
						idx_q <= 5'h00;
						readback_q <= 1'b0;
					end
				end
				mem_cmd_pkg::ST_DECODE: begin
					low_addr_q <= {mbox_q[6], mbox_q[7]}; // [RULE9]
					count_q <= number[4:0];
					state_q <= mem_cmd_pkg::ST_ISSUE;
					if (mbox_q[0][7:3] != `CMD_CODE_MEM_ACCESS) begin
						err_q <= `ERR_COMMAND; // [RULE13]
						state_q <= mem_cmd_pkg::ST_DONE;
					end else if (!is_read && number == 8'h00) begin
						state_q <= mem_cmd_pkg::ST_DONE; // [RULE5]
					end else if (reserved) begin
						err_q <= `ERR_COMMAND; // [RULE3]
						state_q <= mem_cmd_pkg::ST_DONE;
					end else if (!is_read && !count_ok(number, `MAX_WRITE_BYTES)) begin
						err_q <= `ERR_RANGE; // [RULE5]
						state_q <= mem_cmd_pkg::ST_DONE;
					end else if (is_read && !count_ok(number, `MAX_READ_BYTES)) begin
						err_q <= `ERR_RANGE; // [RULE6]
						state_q <= mem_cmd_pkg::ST_DONE;
					end else if (write_barred || (needs_unlock && cmd_password != password_q)) begin
						err_q <= `ERR_RIGHTS; // [RULE4] [RULE7]
						state_q <= mem_cmd_pkg::ST_DONE;
					end
				end
				mem_cmd_pkg::ST_ISSUE: begin
					state_q <= mem_cmd_pkg::ST_WAIT;
				end
				mem_cmd_pkg::ST_WAIT: begin
					if (mem_ack) begin
						state_q <= mem_cmd_pkg::ST_VERIFY;
					end
				end
				mem_cmd_pkg::ST_VERIFY: begin
					if (!is_read && verify_on && !readback_q) begin
						readback_q <= 1'b1; // [RULE2]
						state_q <= mem_cmd_pkg::ST_ISSUE;
					end else begin
						readback_q <= 1'b0;
						if (5'(idx_q + 5'h01) == count_q) begin
							state_q <= mem_cmd_pkg::ST_DONE;
						end else begin
							idx_q <= 5'(idx_q + 5'h01); // [RULE14]
							state_q <= mem_cmd_pkg::ST_ISSUE;
						end
					end
				end
				mem_cmd_pkg::ST_DONE: begin
					if (verify_failed_q && err_q == `ERR_NONE) begin
						err_q <= `ERR_VERIFY;
					end
					busy_q <= 1'b0;
					complete_q <= 1'b1; // [RULE15]
					state_q <= mem_cmd_pkg::ST_IDLE;
				end
				default: state_q <= mem_cmd_pkg::ST_IDLE;
			endcase
		end
	end

	// Done and error events for the interrupt logic.
	assign ev_done = (state_q == mem_cmd_pkg::ST_DONE);
	assign ev_err = ev_done & ((err_q != `ERR_NONE) | verify_failed_q);

	// Verify result: cleared at each start, then set by the first failing readback.
	// The compare is taken with the acknowledge, the one cycle the read byte stands.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			verify_failed_q <= 1'b0;
			verify_addr_q <= 16'h0000;
		end else if (state_q == mem_cmd_pkg::ST_IDLE && start) begin
			verify_failed_q <= 1'b0;
			verify_addr_q <= 16'h0000;
		end else if (state_q == mem_cmd_pkg::ST_WAIT && mem_ack && readback_q && mismatch && !verify_failed_q) begin
			verify_failed_q <= 1'b1; // [RULE2]
			verify_addr_q <= 16'(low_addr_q + {11'h000, idx_q});
		end
	end

	// Mailbox array: APB writes, read data written back by the sequencer.
	// Read data takes priority, though both never meet since APB mailbox writes are refused while busy.
	// Each read byte is captured at its acknowledge, the only edge it is valid at.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `MBOX_COUNT; i++) begin
				mbox_q[i] <= 8'h00;
			end
		end else if (state_q == mem_cmd_pkg::ST_WAIT && mem_ack && is_read) begin
			mbox_q[5'(5'h02 + idx_q)] <= mem_rdata;
		end else if (wr_en && mbox_sel && !busy_q) begin
			mbox_q[mbox_idx] <= pwdata[7:0];
		end
	end

	// Unlock password, writable by software.
	// It is compared only for spaces that need unlocking; other spaces ignore it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			password_q <= `PASSWORD_RESET;
		end else if (wr_en && paddr == `OFS_PASSWORD) begin
			password_q <= pwdata;
		end
	end

	// Sticky interrupt status; a new event wins over a write-one clear.
	// Letting the event win means a completion is never lost to a late clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= '0;
		end else begin
			for (int b = 0; b < `IRQ_WIDTH; b++) begin
				if ((b == `IRQ_DONE_BIT && ev_done) || (b == `IRQ_ERR_BIT && ev_err)) begin
					irq_status_q[b] <= 1'b1;
				end else if (wr_en && paddr == `OFS_IRQ_STATUS && pwdata[b]) begin
					irq_status_q[b] <= 1'b0;
				end
			end
		end
	end

	// Interrupt mask.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= '0;
		end else if (wr_en && paddr == `OFS_IRQ_MASK) begin
			irq_mask_q <= pwdata[`IRQ_WIDTH-1:0];
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	// Read data register, loaded during the setup phase.
	// Loading in setup leaves the word stable for the whole access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (mbox_sel) begin
				prdata <= {24'h000000, mbox_q[mbox_idx]};
			end else begin
				case (paddr)
					`OFS_STATUS: prdata <= {24'h000000, complete_q, err_q, 3'h0, busy_q}; // [RULE15]
					`OFS_IRQ_STATUS: prdata <= {30'h0, irq_status_q};
					`OFS_IRQ_MASK: prdata <= {30'h0, irq_mask_q};
					`OFS_RESULT: prdata <= {15'h0000, verify_failed_q, verify_addr_q};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	logic unused_rd;
	assign unused_rd = rd_en;
endmodule
`default_nettype wire

// file: dv/mem_access_cmd_props.sv
// Port checker for the memory access command interpreter.
`include "mem_cmd_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module mem_access_cmd_props (
	// Clock, reset and APB.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Memory port.
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_ack
);
	logic [7:0] mb_q [8];
	logic [23:0] prev_q;
	logic wr_hit, go, one_ram;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow of the header mailboxes and of the last acknowledged address.
	always_ff @(posedge pclk) begin
		if (wr_hit && paddr[7:5] == 3'h4) begin
			mb_q[paddr[4:2]] <= pwdata[7:0];
		end
		if (mem_ack) begin
			prev_q <= mem_addr;
		end
	end
	// A start, and a start of a one-byte RAM command.
	assign wr_hit = psel && penable && pwrite;
	assign go = wr_hit && paddr == `OFS_CTRL && pwdata[0];
	assign one_ram = go && mb_q[0][7:3] == `CMD_CODE_MEM_ACCESS && mb_q[1] == 8'h41;
	chk_req_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request moved before ack");
	chk_wdata_holds: assert property (mem_req && mem_we && !mem_ack |=> $stable(mem_wdata))
		else $error("write byte moved before ack");
	chk_next_addr: assert property (mem_ack ##1 !mem_req ##1 !mem_req ##1 mem_req |-> mem_addr - prev_q <= 24'h1)
		else $error("next byte address is not the same or one above");
	chk_noop_quiet: assert property (go && mb_q[1][4:0] == 5'h0 |=> !mem_req [*8])
		else $error("zero count touched memory");
	chk_reserved_quiet: assert property (go && mb_q[1][7:5] == 3'h7 |=> !mem_req [*8])
		else $error("reserved space touched memory");
	chk_first_dir: assert property (one_ram |-> ##[1:8] mem_req && mem_we == !mb_q[0][0])
		else $error("first access has wrong direction");
	chk_first_addr: assert property (one_ram |-> ##[1:8] mem_req && mem_addr[15:0] == {mb_q[6], mb_q[7]})
		else $error("first access has wrong address");
	chk_busy_coco: assert property (psel && !penable && !pwrite && paddr == `OFS_STATUS && mem_req
		|=> !prdata[7] && prdata[0])
		else $error("complete flag set while running");
endmodule
bind mem_access_cmd mem_access_cmd_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .mem_req(mem_req), .mem_we(mem_we),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));
`default_nettype wire

// file: dv/mem_model.sv
// Byte memory model on the interpreter's memory port.
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	// Memory port.
	input wire logic pclk,
	input wire logic req,
	input wire logic we,
	input wire logic [23:0] addr,
	input wire logic [7:0] wdata,
	output logic ack,
	output logic [7:0] rdata,
	// Answer delay and stored-bit corruption.
	input wire logic [3:0] lag,
	input wire logic spoil
);
	logic [7:0] mem [logic [23:0]];
	int n = 0;
	initial begin
		ack = 1'b0;
		rdata = 8'h3C;
	end
	// Answers after lag cycles; read data is only valid with the ack.
	always @(posedge pclk) begin
		ack <= 1'b0;
		rdata <= ~rdata;
		if (req && !ack) begin
			if (n < lag) n++;
			else begin
				n = 0;
				ack <= 1'b1;
				if (we) mem[addr] = wdata ^ {7'h0, spoil};
				else rdata <= mem.exists(addr) ? mem[addr] : 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the memory access command interpreter.
`include "mem_cmd_consts.svh"
`timescale 1ns/100ps
`default_nettype none
`define CK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack, irq, spoil, serr;
	logic [7:0] paddr, mem_wdata, mem_rdata;
	logic [31:0] pwdata, prdata, rdv;
	logic [23:0] mem_addr;
	logic [3:0] lag;
	int mismatches = 0;
	int checks_done = 0;
	logic [15:0] tc [6] = '{16'h08C0, 16'h09F0, 16'h08CE, 16'h0800, 16'h09FE, 16'h0906};
	mem_access_cmd DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.irq(irq));
	mem_model mm (.pclk(pclk), .req(mem_req), .we(mem_we), .addr(mem_addr), .wdata(mem_wdata), .ack(mem_ack),
		.rdata(mem_rdata), .lag(lag), .spoil(spoil));
	// One APB transfer; read data and error response land in rdv and serr.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Loads a packet, starts it and polls until the complete flag rises.
	task automatic run(input logic [7:0] cmd, par, input logic [31:0] pw, input logic [15:0] a, input logic [2:0] e);
		int i;
		apb(1'b1, 8'h80, {24'h0, cmd});
		apb(1'b1, 8'h84, {24'h0, par});
		for (i = 0; i < 4; i++) apb(1'b1, 8'h88 + 8'(4 * i), {24'h0, pw[31 - 8 * i -: 8]});
		apb(1'b1, 8'h98, {24'h0, a[15:8]});
		apb(1'b1, 8'h9C, {24'h0, a[7:0]});
		for (i = 0; i < 24; i++) apb(1'b1, 8'hA0 + 8'(4 * i), 32'h40 + i);
		apb(1'b1, `OFS_CTRL, 32'h1);
		i = 0;
		do begin
			apb(1'b0, `OFS_STATUS, 32'h0);
			i++;
		end while (rdv[7] !== 1'b1 && i < 300);
		`CK("status", rdv[7:0], {1'b1, e, 4'h0})
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Clock.
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Watchdog, far beyond the few thousand cycles needed.
	initial begin
		#400000;
		mismatches++;
		close_out();
	end
	// Test sequence.
	initial begin
		int i;
		{presetn, psel, penable, pwrite, paddr, pwdata, spoil} = '0;
		lag = 4'h2;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		run(8'h0A, 8'h44, 32'h0, 16'h12FE, `ERR_NONE);
		`CK("irq masked", irq, 1'b0)
		apb(1'b1, `OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		`CK("irq", irq, 1'b1)
		apb(1'b1, `OFS_IRQ_STATUS, 32'h3);
		repeat (2) @(posedge pclk);
		`CK("irq cleared", irq, 1'b0)
		run(8'h09, 8'h44, 32'h0, 16'h12FE, `ERR_NONE);
		for (i = 0; i < 4; i++) begin
			apb(1'b0, 8'h88 + 8'(4 * i), 32'h0);
			`CK("read byte", rdv[7:0], 8'h40 + 8'(i))
		end
		spoil <= 1'b1;
		run(8'h0A, 8'h42, 32'h0, 16'h0040, `ERR_VERIFY);
		apb(1'b0, `OFS_RESULT, 32'h0);
		`CK("verify addr", rdv, 32'h0001_0040)
		run(8'h08, 8'h42, 32'h0, 16'h0040, `ERR_NONE);
		spoil <= 1'b0;
		run(8'h0B, 8'h41, 32'h0, 16'h0040, `ERR_NONE);
		run(8'h09, 8'h21, 32'h0, 16'h0000, `ERR_RIGHTS);
		run(8'h09, 8'h21, `PASSWORD_RESET, 16'h0000, `ERR_NONE);
		run(8'h08, 8'hA2, 32'h1, 16'h0000, `ERR_RIGHTS);
		lag <= 4'h0;
		for (i = 0; i < 8; i++) begin
			run(8'h09, {i[2:0], 5'h01}, `PASSWORD_RESET, 16'h0000, i == 7 ? `ERR_COMMAND : `ERR_NONE);
		end
		for (i = 0; i < 6; i++) begin
			run(tc[i][15:8], {3'h2, tc[i][7:3]}, 32'h0, 16'h0100, tc[i][2:0]);
			if (i == 1) begin
				apb(1'b0, 8'hE4, 32'h0);
				`CK("last byte", rdv[7:0], 8'h57)
				apb(1'b0, 8'hE8, 32'h0);
				`CK("past count", rdv[7:0], 8'h00)
			end
		end
		run(8'h10, 8'h41, 32'h0, 16'h0000, `ERR_COMMAND);
		apb(1'b0, 8'h40, 32'h0);
		`CK("unmapped", serr, 1'b1)
		close_out();
	end
endmodule
`default_nettype wire
